// ### hdl/supervisor_pkg.sv
// Constants for the supervisor watchdog reset block.
// Assumes a 250 MHz core clock; all counts derive from it.
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  // ****************************************************************
  // Timing in printed units
  // ****************************************************************
  localparam int unsigned RESET_ACTIVE_MS = 500;
  localparam int unsigned WATCHDOG_TIMEOUT_MS = 700;
  localparam int unsigned STROBE_MIN_NS = 500;
  localparam int unsigned DEBOUNCE_MS = 10;
  // ****************************************************************
  // Derived cycle counts
  // ****************************************************************
  localparam longint unsigned RESET_ACTIVE_CYC = (64'(RESET_ACTIVE_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned WATCHDOG_TIMEOUT_CYC = (64'(WATCHDOG_TIMEOUT_MS) * CLK_HZ) / 1000;
  localparam longint unsigned STROBE_MIN_CYC = (64'(STROBE_MIN_NS) * CLK_HZ + 999999999) / 1000000000;
  localparam longint unsigned DEBOUNCE_CYC = (64'(DEBOUNCE_MS) * CLK_HZ + 999) / 1000;
  localparam int CNT_W = 28;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_RUN = 2'h1,
    ST_PB = 2'h3
  } sup_state_t;
endpackage

// ### hdl/sync_two_ff.sv
// Two-flop synchroniser for the asynchronous pin levels.
// Assumes the input is a plain level; only the second stage may be read.
`timescale 1ns/1ps
module sync_two_ff
  import supervisor_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] stage1_reg;
  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= SYNC_RESET;
      sync_out <= SYNC_RESET;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule

// ### hdl/supervisor_watchdog_reset.sv
// Processor supervisor: power reset hold, watchdog and external reset on one shared open-drain line.
// Assumes pin comparators outside report line level and strobe level, and supply-good, asynchronously.
//
// What this block does
// - Hold the line low until the supply has been good for at least 500 ms.
// - Pull a reset when no strobe is seen within the 700 ms watchdog timeout.
// - Drive reset at once whenever the supply is out of tolerance, on power-up and power-down.
// - Drive the line open-drain only, and treat an outside low that lasts the debounce time as a reset.
// - Debounce a push-button closure before acting on it.
// - Keep issuing a fresh reset pulse every timeout while strobes stay absent.
// - Restart the watchdog whenever the line sits at strobe level for at least 500 ns.
// - Stretch an outside reset so the reset pulse lasts at least 500 ms.
`timescale 1ns/1ps
module supervisor_watchdog_reset
  import supervisor_pkg::*;
#(
  parameter longint unsigned RESET_CYCLES = RESET_ACTIVE_CYC,
  parameter longint unsigned TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_CYC,
  parameter longint unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supply_good,
  input wire logic reset_strobe_line_low_in,
  input wire logic reset_strobe_line_strobe_in,
  output logic reset_strobe_line_out,
  output logic reset_strobe_line_oe,
  output logic processor_in_reset
);
  // Counter end values; the counter width covers the longest timing count
  localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STB_LAST = CNT_W'(STROBE_MIN_CYC - 1);

  logic [1:0] pin_sync;
  logic line_low;
  logic strobe_lvl;
  logic supply_sync1_reg;
  logic supply_ok_reg;
  sup_state_t state_reg;
  logic [CNT_W-1:0] hold_cnt_reg;
  logic [CNT_W-1:0] wdog_cnt_reg;
  logic [CNT_W-1:0] deb_cnt_reg;
  logic [CNT_W-1:0] stb_cnt_reg;
  logic drive_reg;
  logic strobe_seen_reg;
  logic stb_armed_reg;
  logic ext_req;
  logic wdog_expire;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  sync_two_ff u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in({reset_strobe_line_strobe_in, reset_strobe_line_low_in}),
    .sync_out(pin_sync)
  );
  assign line_low = pin_sync[0];
  assign strobe_lvl = pin_sync[1];

  // Supply flag through its own two flops so a brown-out edge is clean
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      supply_sync1_reg <= 1'b0;
      supply_ok_reg <= 1'b0;
    end else begin
      supply_sync1_reg <= supply_good;
      supply_ok_reg <= supply_sync1_reg;
    end
  end

  // ****************************************************************
  // Strobe width qualifier
  // ****************************************************************
  // A strobe counts once the line has sat at strobe level for the minimum width; the sync
  // delay is equal on both edges so the width measured here matches the pin.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stb_cnt_reg <= '0;
      stb_armed_reg <= 1'b1;
      strobe_seen_reg <= 1'b0;
    end else begin
      strobe_seen_reg <= 1'b0;
      if (drive_reg || !strobe_lvl || line_low) begin
        stb_cnt_reg <= '0;
        stb_armed_reg <= 1'b1;
      end else if (stb_armed_reg) begin
        if (stb_cnt_reg >= STB_LAST) begin
          strobe_seen_reg <= 1'b1;
          stb_armed_reg <= 1'b0;
        end else begin
          stb_cnt_reg <= stb_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Outside reset debounce
  // ****************************************************************
  // Only a low seen while we release the line is outside; our own drive is masked
  // Holds at the end count while the low persists; any release starts the count over
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      deb_cnt_reg <= '0;
    end else if (drive_reg || !line_low) begin
      deb_cnt_reg <= '0;
    end else if (deb_cnt_reg < DEB_LAST) begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end
  assign ext_req = !drive_reg && line_low && (deb_cnt_reg >= DEB_LAST);

  // ****************************************************************
  // Watchdog timer
  // ****************************************************************
  // Saturates at the last count so a missed exit never wraps into a long silent period
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wdog_cnt_reg <= '0;
    end else if (state_reg != ST_RUN || strobe_seen_reg) begin
      wdog_cnt_reg <= '0;
    end else if (!wdog_expire) begin
      wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
  end
  assign wdog_expire = (wdog_cnt_reg >= TMO_LAST);

  // ****************************************************************
  // Reset sequencing
  // ****************************************************************
  // Timer restarts on each entry to hold, so repeated timeouts give repeated pulses
  // Power hold, watchdog pulse and stretched outside reset share one timer and one minimum width
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_HOLD;
      hold_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (!supply_ok_reg) begin
            hold_cnt_reg <= '0;
          end else if (hold_cnt_reg >= RST_LAST) begin
            state_reg <= ST_RUN;
            hold_cnt_reg <= '0;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
          end
        end
        ST_RUN: begin
          hold_cnt_reg <= '0;
          if (!supply_ok_reg) begin
            state_reg <= ST_HOLD;
          end else if (ext_req) begin
            state_reg <= ST_PB;
          end else if (wdog_expire && !strobe_seen_reg) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_PB: begin
          // Outside reset: take the line over once the button lets go, then stretch
          if (!supply_ok_reg) begin
            state_reg <= ST_HOLD;
          end else if (!line_low) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
          hold_cnt_reg <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Open-drain output
  // ****************************************************************
  // The line is only ever pulled low; released means high by the outside pull-up
  // Supply loss reaches the pin one cycle sooner by not waiting for the state change
  function automatic logic state_reg_next_hold();
    return (state_reg == ST_HOLD) || !supply_ok_reg;
  endfunction

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive_reg <= 1'b1;
    end else begin
      drive_reg <= state_reg_next_hold();
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reset_strobe_line_oe <= 1'b1;
    end else begin
      reset_strobe_line_oe <= state_reg_next_hold();
    end
  end

  // Outside reset shows as processor reset while the device itself still releases the line
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      processor_in_reset <= 1'b1;
    end else begin
      processor_in_reset <= state_reg_next_hold() || ext_req || state_reg == ST_PB;
    end
  end

  // Data side of the open-drain pad stays at zero from a flop; only the enable moves
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reset_strobe_line_out <= 1'b0;
    end else begin
      reset_strobe_line_out <= 1'b0;
    end
  end
endmodule

// ### sim/supervisor_monitor.sv
// Checker on the supervisor top pins.
// Assumes a bind from the bench that hands on the shortened cycle counts.
`timescale 1ns/1ps
module supervisor_monitor #(
  parameter longint unsigned RESET_CYCLES = 200,
  parameter longint unsigned TIMEOUT_CYCLES = 400,
  parameter longint unsigned DEBOUNCE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic supply_good,
  input wire logic reset_strobe_line_low_in,
  input wire logic reset_strobe_line_strobe_in,
  input wire logic reset_strobe_line_out,
  input wire logic reset_strobe_line_oe,
  input wire logic processor_in_reset
);
  int hold_cnt;
  int idle_cnt;
  int ext_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Run lengths of drive, silence and outside low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= 0;
      idle_cnt <= 0;
      ext_cnt <= 0;
    end else begin
      hold_cnt <= reset_strobe_line_oe ? hold_cnt + 1 : 0;
      idle_cnt <= (reset_strobe_line_oe || reset_strobe_line_strobe_in) ? 0 : idle_cnt + 1;
      ext_cnt <= (reset_strobe_line_low_in && !reset_strobe_line_oe) ? ext_cnt + 1 : 0;
    end
  end
  open_drain_a:
    assert property (reset_strobe_line_out == 1'b0) else $error("line data not zero");
  brownout_drive_a:
    assert property ($fell(supply_good) |-> ##[1:6] reset_strobe_line_oe) else $error("no drive on supply loss");
  pulse_length_a:
    assert property ($fell(reset_strobe_line_oe) |-> hold_cnt >= RESET_CYCLES) else $error("reset too short");
  watchdog_bound_a:
    assert property (idle_cnt <= TIMEOUT_CYCLES + 10) else $error("watchdog never fired");
  drive_means_reset_a:
    assert property ($rose(reset_strobe_line_oe) |-> ##[0:2] processor_in_reset) else $error("drive without reset");
  outside_reset_a:
    assert property (ext_cnt == DEBOUNCE_CYCLES + 6 |-> processor_in_reset) else $error("outside low ignored");
  debounce_min_a:
    assert property ($rose(processor_in_reset) && reset_strobe_line_low_in && !reset_strobe_line_oe
      |-> ext_cnt >= DEBOUNCE_CYCLES) else $error("outside low not debounced");
  stretch_start_a:
    assert property ($fell(reset_strobe_line_low_in) && processor_in_reset && !$past(reset_strobe_line_oe)
      && !reset_strobe_line_oe |-> ##[1:6] reset_strobe_line_oe) else $error("outside reset not stretched");
endmodule

// ### sim/line_partner.sv
// Processor and push-button on the shared reset line.
// Assumes the bench asks for strobes and presses; levels reach the block as comparator flags.
`timescale 1ns/1ps
module line_partner (
  input wire logic oe,
  input wire logic strobe_req,
  input wire logic button_req,
  output logic low_in,
  output logic strobe_in
);
  // A hard low from either party wins over the divider strobe
  assign low_in = oe | button_req;
  // A hard low is also below the strobe level; width and period come from the bench
  assign strobe_in = strobe_req | low_in;
endmodule

// ### sim/tb_top.sv
// Bench for the supervisor: power hold, watchdog, push-button and brown-out.
// Assumes shortened counts; the partner model plays processor and button.
`timescale 1ns/1ps
module tb_top;
  localparam longint unsigned RST_C = 200;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic supply_good = 1'b0;
  logic strobe_req = 1'b0;
  logic button_req = 1'b0;
  logic low_in, strobe_in, line_out, oe, pir;
  int miscompares = 0;
  int checks = 0;
  always #2 core_clk = ~core_clk;
  supervisor_watchdog_reset #(.RESET_CYCLES(RST_C), .TIMEOUT_CYCLES(400), .DEBOUNCE_CYCLES(20)) dut (
    .core_clk(core_clk), .resetn(resetn), .supply_good(supply_good), .reset_strobe_line_low_in(low_in),
    .reset_strobe_line_strobe_in(strobe_in), .reset_strobe_line_out(line_out), .reset_strobe_line_oe(oe),
    .processor_in_reset(pir));
  line_partner far (.oe(oe), .strobe_req(strobe_req), .button_req(button_req), .low_in(low_in), .strobe_in(strobe_in));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Waits past the edge so registered outputs have landed
  task automatic chk(input string nm, input logic seen_v, input logic exp_v);
    #1;
    checks++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, exp_v, seen_v);
    end
  endtask
  // Only the raised request is dropped, so back-to-back calls of different kinds never assign one signal twice
  task automatic pulse(input bit btn, input int w);
    if (btn) begin
      button_req <= 1'b1;
    end else begin
      strobe_req <= 1'b1;
    end
    tick(w);
    if (btn) begin
      button_req <= 1'b0;
    end else begin
      strobe_req <= 1'b0;
    end
  endtask
  task automatic wait_low;
    int n;
    n = 0;
    while (oe !== 1'b0 && n < 1000) begin
      tick(1);
      #1;
      n++;
    end
    chk("oe_released", oe, 1'b0);
  endtask
  task automatic power_up;
    supply_good <= 1'b1;
    tick(int'(RST_C) - 5);
    chk("oe_hold", oe, 1'b1);
    tick(15);
    chk("oe_release", oe, 1'b0);
    chk("line_out", line_out, 1'b0);
  endtask
  task automatic results;
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(27236));
    tick(3);
    resetn <= 1'b1;
    tick(20 + $urandom % 20);
    power_up();
    repeat (4) begin
      tick(150 + $urandom % 100);
      pulse(0, 130);
      chk("oe_strobed", oe, 1'b0);
    end
    tick(100);
    pulse(0, 60);
    tick(210);
    chk("oe_short_strobe", oe, 1'b0);
    tick(60);
    chk("oe_timeout", oe, 1'b1);
    wait_low();
    tick(385);
    chk("oe_repeat_early", oe, 1'b0);
    tick(25);
    chk("oe_repeat", oe, 1'b1);
    wait_low();
    tick(50);
    pulse(0, 130);
    pulse(1, 10);
    tick(30);
    chk("pir_bounce", pir, 1'b0);
    pulse(1, 60);
    chk("pir_button", pir, 1'b1);
    tick(6);
    chk("oe_stretch", oe, 1'b1);
    tick(int'(RST_C) - 10);
    chk("oe_stretch_end", oe, 1'b1);
    wait_low();
    tick(20);
    chk("oe_no_self", oe, 1'b0);
    tick(1);
    pulse(0, 130);
    tick(20);
    supply_good <= 1'b0;
    tick(6);
    chk("oe_brownout", oe, 1'b1);
    tick(5 + $urandom % 50);
    power_up();
    results();
  end
  initial begin
    #60000;
    miscompares++;
    results();
  end
endmodule
bind supervisor_watchdog_reset supervisor_monitor #(.RESET_CYCLES(RESET_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) mon (.core_clk(core_clk), .resetn(resetn), .supply_good(supply_good),
  .reset_strobe_line_low_in(reset_strobe_line_low_in), .reset_strobe_line_strobe_in(reset_strobe_line_strobe_in),
  .reset_strobe_line_out(reset_strobe_line_out), .reset_strobe_line_oe(reset_strobe_line_oe),
  .processor_in_reset(processor_in_reset));
